// [rmm_pkg.sv]
// shared constants and types for the rms and mean-absolute-value measurement block
package rmm_pkg;
  localparam int CLOCK_HZ = 100_000_000;
  localparam int SAMPLE_RATE_HZ = 8_000;
  localparam int TICK_CYCLES = CLOCK_HZ / SAMPLE_RATE_HZ;
  localparam int NUM_CH = 7;
  localparam int NUM_CUR = 4;
  localparam int NUM_PHASE = 3;
  localparam int SAMPLE_W = 24;
  localparam int RMS_W = 24;
  localparam int ABS_MEAN_W = 20;
  localparam int DSP_W = 28;
  localparam int WORD_W = 32;
  localparam int SQ_W = 48;
  localparam int RAD_W = 49;
  localparam int OFFSET_SCALE_SHIFT = 7;
  localparam int LPF_SHIFT = 9;
  localparam int ABS_MEAN_SHIFT = 9;
  localparam int ABS_MEAN_SCALE_SHIFT = 4;
  localparam int LRIP_LOG2 = 13;
  localparam int NEUTRAL_CH = 3;
  localparam int NSEL_BIT = 0;
  localparam int READY_FLAG_BIT = 17;
  localparam logic [23:0] ROOT_MSB = 24'h800000;
  localparam logic [23:0] ROOT_LSB = 24'h000001;
  localparam logic [23:0] SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;

  typedef enum logic [1:0] {
    PM_FULL = 2'b00,
    PM_REDUCED_ONE = 2'b01,
    PM_REDUCED_TWO = 2'b10,
    PM_REDUCED_THREE = 2'b11
  } rmm_power_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SQ = 3'b001,
    ST_OFS = 3'b010,
    ST_ROOT = 3'b011,
    ST_STORE = 3'b100,
    ST_DONE = 3'b101
  } rmm_state_t;

  // channel order: three phase currents, neutral current, three phase voltages
  typedef struct packed {
    logic signed [23:0] cur_a;
    logic signed [23:0] cur_b;
    logic signed [23:0] cur_c;
    logic signed [23:0] cur_n;
    logic signed [23:0] volt_a;
    logic signed [23:0] volt_b;
    logic signed [23:0] volt_c;
  } rmm_samples_t;

  typedef struct packed {
    logic neutral_source_select;
    logic run;
    rmm_power_mode_t power_mode;
  } rmm_ctrl_t;
endpackage : rmm_pkg

// [rmm_core.sv]
// rms, low-ripple rms and mean-absolute-value measurement core
`timescale 1ns/1ps
`default_nettype none
module rmm_core
  import rmm_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter int LPF_K = LPF_SHIFT,
  parameter int ABS_K = ABS_MEAN_SHIFT,
  parameter int LRIP_BITS = LRIP_LOG2
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire rmm_samples_t samples,
  input wire rmm_ctrl_t ctrl,
  input wire logic [3:0][31:0] offset_word,
  input wire logic data_ready_clear,
  input wire logic data_ready_mask,
  output logic [6:0][31:0] rms_word,
  output logic [3:0][31:0] rms_averaged_word,
  output logic [2:0][31:0] abs_mean_word,
  output logic [31:0] phase_current_sum_word,
  output logic [31:0] primary_status_register,
  output logic data_ready_flag,
  output logic data_ready_irq_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic signed [23:0] pick_ch(input rmm_samples_t s, input logic [2:0] idx,
                                                 input logic nsel, input logic signed [23:0] nsum);
    logic signed [23:0] v;
    v = s.cur_a;
    case (idx)
      3'h0: v = s.cur_a;
      3'h1: v = s.cur_b;
      3'h2: v = s.cur_c;
      3'h3: v = nsel ? nsum : s.cur_n;
      3'h4: v = s.volt_a;
      3'h5: v = s.volt_b;
      3'h6: v = s.volt_c;
      default: v = s.cur_a;
    endcase
    return v;
  endfunction : pick_ch

  function automatic logic signed [23:0] sat24(input logic signed [25:0] x);
    logic signed [23:0] r;
    r = x[23:0];
    if (x > 26'sh7FFFFF)
      r = SAT_POS;
    else if (x < -26'sh800000)
      r = SAT_NEG;
    return r;
  endfunction : sat24

  ////////////////////////////////////////////////////////////////////////////////
  // 8 kHz computation tick

  logic [15:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 16'(TICK_COUNT - 1));

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  logic full_mode;
  logic abs_mode;
  logic start;
  assign full_mode = (ctrl.power_mode == PM_FULL);
  assign abs_mode = (ctrl.power_mode == PM_FULL) || (ctrl.power_mode == PM_REDUCED_ONE);
  assign start = tick && ctrl.run && full_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // phase current sum

  logic signed [25:0] next_sum;
  logic signed [27:0] phase_sum;
  logic signed [23:0] phase_sum_sat;
  assign next_sum = 26'(samples.cur_a) + 26'(samples.cur_b) + 26'(samples.cur_c);
  assign phase_sum_sat = sat24(26'(phase_sum));

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      phase_sum <= 28'sh0000000;
    else if (tick && ctrl.run)
      phase_sum <= 28'(next_sum);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequential rms engine, one channel at a time

  rmm_state_t state;
  logic [2:0] ch;
  rmm_samples_t cap;
  logic [47:0] low_pass_stage [0:6];
  logic [47:0] rad;
  logic [23:0] root;
  logic [23:0] mask;
  logic [6:0][23:0] rms;

  logic signed [23:0] cur;
  logic signed [47:0] cur_w;
  logic [47:0] sq_val;
  logic signed [48:0] lpf_diff;
  logic [47:0] next_lpf;
  logic signed [27:0] off28;
  logic signed [48:0] rad_sum;
  logic [23:0] trial;
  logic [47:0] trial_sq;

  assign cur = pick_ch(cap, ch, ctrl.neutral_source_select, phase_sum_sat);
  assign cur_w = 48'(cur);
  assign sq_val = 48'(cur_w * cur_w);
  assign lpf_diff = $signed({1'b0, sq_val}) - $signed({1'b0, low_pass_stage[ch]});
  assign next_lpf = 48'($signed({1'b0, low_pass_stage[ch]}) + (lpf_diff >>> LPF_K));
  assign off28 = (ch < 3'(NUM_CUR)) ? 28'(signed'(offset_word[ch[1:0]][23:0])) : 28'sh0000000;
  assign rad_sum = $signed({1'b0, low_pass_stage[ch]}) + $signed({{14{off28[27]}}, off28, 7'h00});
  assign trial = root | mask;
  assign trial_sq = 48'(trial) * 48'(trial);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      ch <= 3'h0;
      cap <= '0;
      rad <= 48'h000000000000;
      root <= 24'h000000;
      mask <= ROOT_MSB;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (start)
          begin
            cap <= samples;
            ch <= 3'h0;
            state <= ST_SQ;
          end
        ST_SQ:
          state <= ST_OFS;
        ST_OFS:
        begin
          rad <= rad_sum[48] ? 48'h000000000000 : rad_sum[47:0];
          root <= 24'h000000;
          mask <= ROOT_MSB;
          state <= ST_ROOT;
        end
        ST_ROOT:
        begin
          if (trial_sq <= rad)
            root <= trial;
          mask <= mask >> 1;
          if (mask == ROOT_LSB)
            state <= ST_STORE;
        end
        ST_STORE:
        begin
          ch <= ch + 3'h1;
          state <= (ch == 3'(NUM_CH - 1)) ? ST_DONE : ST_SQ;
        end
        ST_DONE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        low_pass_stage[i] <= 48'h000000000000;
    end
    else if (state == ST_SQ)
      low_pass_stage[ch] <= next_lpf;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rms <= '0;
    else if (state == ST_STORE)
      rms[ch] <= root;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low-ripple averages of the four current channels

  logic [LRIP_BITS-1:0] win_cnt;
  logic win_last;
  logic [3:0][36:0] lrip_acc;
  logic [3:0][23:0] lrip;
  logic [36:0] lrip_total;
  assign win_last = (win_cnt == {LRIP_BITS{1'b1}});
  assign lrip_total = lrip_acc[ch[1:0]] + 37'(root);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      win_cnt <= '0;
    else if (state == ST_DONE)
      win_cnt <= win_cnt + 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lrip_acc <= '0;
      lrip <= '0;
    end
    else if (state == ST_STORE && ch < 3'(NUM_CUR))
    begin
      if (win_last)
      begin
        lrip[ch[1:0]] <= 24'(lrip_total >> LRIP_BITS);
        lrip_acc[ch[1:0]] <= 37'h0000000000;
      end
      else
        lrip_acc[ch[1:0]] <= lrip_total;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mean absolute value of the phase currents

  logic [2:0][23:0] abs_filt;
  logic signed [2:0][23:0] phase_in;
  assign phase_in = {samples.cur_c, samples.cur_b, samples.cur_a};

  generate
    for (genvar g = 0; g < NUM_PHASE; g++)
    begin : g_abs_mean
      logic [23:0] mag;
      logic signed [24:0] mdiff;
      assign mag = phase_in[g][23] ? 24'(-phase_in[g]) : 24'(phase_in[g]);
      assign mdiff = $signed({1'b0, mag}) - $signed({1'b0, abs_filt[g]});
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
          abs_filt[g] <= 24'h000000;
        else if (tick && ctrl.run && abs_mode)
          abs_filt[g] <= 24'($signed({1'b0, abs_filt[g]}) + (mdiff >>> ABS_K));
      end
      assign abs_mean_word[g] = {12'h000, 20'(abs_filt[g] >> ABS_MEAN_SCALE_SHIFT)};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // data-ready status and interrupt

  logic ready_set;
  assign ready_set = (state == ST_DONE);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      data_ready_flag <= 1'b0;
    else if (ready_set)
      data_ready_flag <= 1'b1;
    else if (data_ready_clear)
      data_ready_flag <= 1'b0;
  end

  assign data_ready_irq_n = !(data_ready_flag && data_ready_mask);
  assign primary_status_register = 32'(data_ready_flag) << READY_FLAG_BIT;

  ////////////////////////////////////////////////////////////////////////////////
  // host word formatting

  generate
    for (genvar r = 0; r < NUM_CH; r++)
    begin : g_rms_word
      assign rms_word[r] = {8'h00, rms[r]};
    end
    for (genvar a = 0; a < NUM_CUR; a++)
    begin : g_lrip_word
      assign rms_averaged_word[a] = {8'h00, lrip[a]};
    end
  endgenerate

  assign phase_current_sum_word = {4'h0, phase_sum};

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_start;
    state == ST_IDLE && start;
  endsequence

  sequence s_done_soon;
    ##[1:300] state == ST_DONE;
  endsequence

  reduced_no_rms_a: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_IDLE && !full_mode) |=> state == ST_IDLE)
    else $error("rms engine started outside full power mode");

  cycle_done_a: assert property (@(posedge clock) disable iff (!nrst)
    s_start |-> s_done_soon)
    else $error("computation cycle did not finish in time");

  ready_set_a: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_DONE) |=> data_ready_flag && (data_ready_irq_n == !data_ready_mask))
    else $error("data ready not raised at end of cycle");

  root_exact_a: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_STORE) |-> (48'(root) * 48'(root) <= rad) &&
      ((49'(root) + 49'h1) * (49'(root) + 49'h1) > 49'(rad)))
    else $error("square root result wrong");

  clamp_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_OFS && rad_sum[48]) |=> rad == 48'h000000000000)
    else $error("negative radicand not clamped");

  neutral_sel_a: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_SQ && ch == 3'(NEUTRAL_CH) && ctrl.neutral_source_select) |->
      cur == sat24(26'(cap.cur_a) + 26'(cap.cur_b) + 26'(cap.cur_c)))
    else $error("neutral source selection wrong");

  abs_mean_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !(tick && ctrl.run && abs_mode) |=> $stable(abs_filt))
    else $error("mean absolute value moved while inactive");

  lrip_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !(state == ST_STORE && win_last) |=> $stable(lrip))
    else $error("low-ripple value changed mid-window");

  phase_sum_load_a: assert property (@(posedge clock) disable iff (!nrst)
    (tick && ctrl.run) |=> phase_sum == 28'($past(next_sum)))
    else $error("phase current sum not captured");

  ready_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (data_ready_clear && state != ST_DONE) |=> !data_ready_flag)
    else $error("data ready flag not cleared");

endmodule : rmm_core
`default_nettype wire

// [rmm_host.sv]
// host model that reads results after the data-ready interrupt
`timescale 1ns/1ps
`default_nettype none
module rmm_host
  import rmm_pkg::*;
#(
  parameter int LAG = 3
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic data_ready_irq_n,
  input wire logic [31:0] rms_in,
  output logic data_ready_clear,
  output logic [31:0] rms_seen,
  output logic [15:0] reads
);
  logic [3:0] lag_cnt;
  ////////////////////////////////////////////////////////////////
  // wait LAG cycles after the interrupt, read, then clear the flag
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lag_cnt <= 4'h0;
      data_ready_clear <= 1'b0;
      rms_seen <= 32'h00000000;
      reads <= 16'h0000;
    end
    else if (data_ready_clear)
    begin
      data_ready_clear <= 1'b0;
      lag_cnt <= 4'h0;
    end
    else if (enable && !data_ready_irq_n)
    begin
      lag_cnt <= lag_cnt + 4'h1;
      if (lag_cnt == 4'(LAG))
      begin
        rms_seen <= rms_in;
        reads <= reads + 16'h0001;
        data_ready_clear <= 1'b1;
      end
    end
  end
endmodule : rmm_host
`default_nettype wire

// [tb.sv]
// self-checking bench for the rms measurement core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rmm_pkg::*;
  localparam int TK = 250;
  logic clock;
  logic nrst;
  rmm_samples_t samples;
  rmm_ctrl_t ctrl;
  logic [3:0][31:0] offset_word;
  logic data_ready_mask;
  logic auto_ack;
  logic data_ready_clear;
  logic [6:0][31:0] rms_word;
  logic [3:0][31:0] rms_averaged_word;
  logic [2:0][31:0] abs_mean_word;
  logic [31:0] phase_current_sum_word;
  logic [31:0] primary_status_register;
  logic data_ready_flag;
  logic data_ready_irq_n;
  logic [31:0] host_rms;
  logic [15:0] host_reads;
  logic [31:0] held;
  logic [2:0][31:0] held_mean;
  logic [6:0][31:0] exp_rms;
  int num_errors = 0;
  int check_count = 0;
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

  rmm_core #(.TICK_COUNT(TK), .LRIP_BITS(3)) dut (.clock(clock), .nrst(nrst), .samples(samples),
    .ctrl(ctrl), .offset_word(offset_word), .data_ready_clear(data_ready_clear),
    .data_ready_mask(data_ready_mask), .rms_word(rms_word), .rms_averaged_word(rms_averaged_word),
    .abs_mean_word(abs_mean_word), .phase_current_sum_word(phase_current_sum_word),
    .primary_status_register(primary_status_register), .data_ready_flag(data_ready_flag),
    .data_ready_irq_n(data_ready_irq_n));
  rmm_host host (.clock(clock), .nrst(nrst), .enable(auto_ack), .data_ready_irq_n(data_ready_irq_n),
    .rms_in(rms_word[0]), .data_ready_clear(data_ready_clear), .rms_seen(host_rms), .reads(host_reads));

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic set_samples(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
    input logic [23:0] n);
    samples = {a, b, c, n, 24'h000000, 24'h000000, 24'h000000};
  endtask : set_samples

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (40000) @(posedge clock);
    num_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    samples = '0;
    ctrl = '0;
    offset_word = '0;
    data_ready_mask = 1'b0;
    auto_ack = 1'b0;
    step(10);
    nrst = 1'b1;
    set_samples(24'h100000, 24'h200000, 24'h300000, 24'h100000);
    step(3 * TK);
    `CHK(rms_word[0], 32'h00000000)
    `CHK(data_ready_flag, 1'b0)
    `CHK(phase_current_sum_word, 32'h00000000)
    `CHK(abs_mean_word[1], 32'h00000000)
    $display("test stopped done");
    offset_word[0] = 32'h00000020;
    offset_word[1] = 32'h0FFFFFFF;
    offset_word[2] = 32'h00000200;
    offset_word[3] = 32'h00000008;
    set_samples(24'h000000, 24'h000000, 24'h000000, 24'h100000);
    ctrl.neutral_source_select = 1'b1;
    ctrl.power_mode = PM_FULL;
    ctrl.run = 1'b1;
    data_ready_mask = 1'b1;
    for (int k = 0; k < 600 && data_ready_flag !== 1'b1; k++)
      step(1);
    `CHK(data_ready_flag, 1'b1)
    `CHK(data_ready_irq_n, 1'b0)
    `CHK(primary_status_register, 32'h00020000)
    data_ready_mask = 1'b0;
    step(1);
    `CHK(data_ready_irq_n, 1'b1)
    data_ready_mask = 1'b1;
    auto_ack = 1'b1;
    step(20);
    `CHK(data_ready_flag, 1'b0)
    `CHK(host_rms, 32'h00000040)
    $display("test ready flag done");
    step(20 * TK);
    exp_rms = {32'h0, 32'h0, 32'h0, 32'h20, 32'h100, 32'h0, 32'h40};
    for (int k = 0; k < 7; k++)
      `CHK(rms_word[k], exp_rms[k])
    for (int k = 0; k < 4; k++)
      `CHK(rms_averaged_word[k], exp_rms[k])
    `CHK(host_reads > 16'd10, 1'b1)
    $display("test offset and average done");
    ctrl.power_mode = PM_REDUCED_ONE;
    set_samples(24'h100000, 24'h200000, 24'hFFFFB0, 24'h000000);
    step(2 * TK);
    `CHK(rms_word[0], 32'h00000040)
    `CHK(data_ready_flag, 1'b0)
    `CHK(abs_mean_word[0][31:20], 12'h000)
    `CHK(phase_current_sum_word, 32'h002FFFB0)
    held = abs_mean_word[0];
    step(TK);
    `CHK(abs_mean_word[0] != held, 1'b1)
    ctrl.power_mode = PM_REDUCED_TWO;
    set_samples(24'h100000, 24'h200000, 24'hCFFFFB, 24'h000000);
    step(TK);
    held = abs_mean_word[0];
    step(2 * TK);
    `CHK(abs_mean_word[0], held)
    `CHK(phase_current_sum_word, 32'h0FFFFFFB)
    $display("test reduced modes done");
    ctrl.power_mode = PM_FULL;
    ctrl.neutral_source_select = 1'b0;
    set_samples(24'h100000, 24'h200000, 24'hCFFFFB, 24'h100000);
    step(2 * TK);
    `CHK(rms_word[0] != 32'h00000040, 1'b1)
    `CHK(rms_word[3] != 32'h00000020, 1'b1)
    `CHK(rms_word[0][31:24], 8'h00)
    held = rms_word[0];
    held_mean = abs_mean_word;
    step(TK);
    `CHK(rms_word[0] != held, 1'b1)
    `CHK(abs_mean_word[1] != held_mean[1], 1'b1)
    `CHK(abs_mean_word[2] != held_mean[2], 1'b1)
    $display("test full mode done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
